// >>> dv/mr1d_ctrl_model.sv
// Memory controller model issuing mode-set commands
`timescale 1ns/100ps
module mr1d_ctrl_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic go_i,
   input wire logic [21:0] word_i,
   output logic mode_set_o,
   output logic [1:0] bank_group_o,
   output logic [1:0] bank_o,
   output logic [17:0] addr_o
);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_set_o <= 1'h0;
         {bank_group_o, bank_o, addr_o} <= 22'h000000;
      end else if (go_i) begin
         mode_set_o <= 1'h1;
         {bank_group_o, bank_o, addr_o} <= word_i & 22'h1DFFFF;
      end else begin
         // Released bus inverts the held word every cycle
         mode_set_o <= 1'h0;
         {bank_group_o, bank_o, addr_o} <= ~{bank_group_o, bank_o, addr_o};
      end
   end
endmodule

// >>> dv/tb.sv
// Self-checking bench for the second mode register block
`timescale 1ns/100ps
module tb;
   logic clk, rst_n, go, ms, x8, sr, tp, cmd, cw, mk, iv;
   logic oe, xs, trn, lr, wok, ex, exw, bm, bi;
   logic [21:0] w;
   logic [1:0] bg, ba, drv;
   logic [17:0] ad;
   logic [2:0] wtt, pk, term, eq;
   mr1d_pkg::mr1d_lat_type rcl, wcl, rl, wl;
   int num_errors = 0;
   int samples_checked = 0;
   // ------------------------------
   // Instances
   // ------------------------------
   mr1d_ctrl_model ctrl (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .word_i(w),
      .mode_set_o(ms), .bank_group_o(bg), .bank_o(ba), .addr_o(ad));
   mr1d_core uut (.clk_i(clk), .rst_n_i(rst_n), .mode_set_i(ms), .bank_group_i(bg),
      .bank_i(ba), .addr_i(ad), .is_x8_i(x8), .self_refresh_i(sr), .term_pin_i(tp),
      .cmd_i(cmd), .cmd_is_write_i(cw), .read_column_latency_i(rcl),
      .write_column_latency_i(wcl), .write_time_termination_i(wtt),
      .parked_termination_i(pk), .mask_req_i(mk), .inversion_req_i(iv),
      .output_enable_o(oe), .extra_termination_strobe_o(xs), .termination_o(term),
      .strobe_alignment_training_o(trn), .receiver_equalizer_o(eq),
      .driver_strength_o(drv), .loop_running_o(lr), .write_loop_ok_o(wok),
      .read_latency_o(rl), .write_latency_o(wl), .exec_cmd_o(ex),
      .exec_is_write_o(exw), .write_byte_mask_o(bm), .bus_inversion_o(bi));
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   // ------------------------------
   // Helpers
   // ------------------------------
   task chk(input string n, input logic [21:0] s, input logic [21:0] e);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task mrs(input logic [21:0] v);
      @(posedge clk);
      go <= 1'h1;
      w <= v;
      @(posedge clk);
      go <= 1'h0;
      repeat (5) @(posedge clk);
      #1;
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task t_fields;
      mrs(22'h042DD3);
      chk("oe", 22'(oe), 22'h1);
      chk("xs", 22'(xs), 22'h1);
      chk("term", 22'(term), 22'h5);
      chk("trn", 22'(trn), 22'h1);
      chk("eq", 22'(eq), 22'h6);
      chk("rl", 22'(rl), 22'h12);
      chk("wl", 22'(wl), 22'h11);
      chk("drv", 22'(drv), 22'h1);
      chk("lr", 22'(lr), 22'h1);
      chk("mask", 22'({bm, bi}), 22'h0);
      $display("test fields done");
   endtask
   task t_select;
      mrs(22'h081FFE);
      chk("term", 22'(term), 22'h5);
      chk("eq", 22'(eq), 22'h6);
      chk("drv", 22'(drv), 22'h1);
      $display("test select done");
   endtask
   task t_term;
      @(posedge clk);
      tp <= 1'h0;
      repeat (6) @(posedge clk);
      #1;
      chk("parked", 22'(term), 22'h2);
      mrs(22'h043DD3);
      chk("oe", 22'(oe), 22'h0);
      chk("term", 22'(term), 22'h0);
      @(posedge clk);
      tp <= 1'h1;
      $display("test termination done");
   endtask
   task t_cmd(input logic [1:0] code, input int al);
      int n;
      logic hit;
      hit = 1'h0;
      mrs(22'h040001 | {17'h0, code, 3'h0});
      chk("rl", 22'(rl), 22'(10 + al));
      chk("wl", 22'(wl), 22'(9 + al));
      @(posedge clk);
      cmd <= 1'h1;
      cw <= code[0];
      for (n = 1; n < 40; n++) begin
         @(posedge clk);
         cmd <= 1'h0;
         #1;
         if (ex === 1'h1) begin
            hit = 1'h1;
            break;
         end
      end
      if (!hit) begin
         num_errors++;
         final_report;
      end
      chk("hold", 22'(n), 22'(al + 1));
      chk("kind", 22'(exw), {21'h0, code[0]});
      @(posedge clk);
      #1;
      chk("wterm", 22'(term), code[0] ? 22'(wtt) : 22'h0);
      $display("test command %0d done", code);
   endtask
   task t_loop;
      @(posedge clk);
      sr <= 1'h1;
      repeat (8) @(posedge clk);
      #1;
      chk("lr", 22'(lr), 22'h0);
      chk("wok", 22'(wok), 22'h0);
      @(posedge clk);
      sr <= 1'h0;
      repeat (8) @(posedge clk);
      #1;
      chk("lr", 22'(lr), 22'h1);
      chk("wok", 22'(wok), 22'h1);
      @(posedge clk);
      tp <= 1'h0;
      wtt <= 3'h0;
      mrs(22'h040000);
      chk("lr", 22'(lr), 22'h0);
      chk("wok", 22'(wok), 22'h1);
      chk("parked", 22'(term), 22'h2);
      mrs(22'h040001);
      chk("lr", 22'(lr), 22'h1);
      @(posedge clk);
      tp <= 1'h1;
      wtt <= 3'h1;
      $display("test loop done");
   endtask
   task t_x4;
      @(posedge clk);
      x8 <= 1'h0;
      mrs(22'h040801);
      chk("xs", 22'(xs), 22'h0);
      chk("mask", 22'({bm, bi}), 22'h3);
      $display("test x4 done");
   endtask
   initial begin
      {rst_n, go, cmd, cw, sr} = 5'h0;
      {x8, tp, mk, iv} = 4'hF;
      w = 22'h0;
      rcl = 6'h0A;
      wcl = 6'h09;
      wtt = 3'h1;
      pk = 3'h2;
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      t_fields;
      t_select;
      t_term;
      t_cmd(2'h0, 0);
      t_cmd(2'h1, 9);
      t_cmd(2'h2, 8);
      t_cmd(2'h3, 0);
      t_loop;
      t_x4;
      final_report;
   end
endmodule

// >>> include/mr1d_params.svh
// Constants for the second mode register decode block
`ifndef MR1D_PARAMS_SVH
`define MR1D_PARAMS_SVH
`define MR1D_REG_W 22
`define MR1D_REG_INDEX 3'h1
`define MR1D_SEL_HI 20
`define MR1D_SEL_LO 18
`define MR1D_RSVD_A 21
`define MR1D_RSVD_B 17
`define MR1D_EQ_HI 13
`define MR1D_OUT_OFF 12
`define MR1D_XSTROBE 11
`define MR1D_NOM_HI 10
`define MR1D_NOM_LO 8
`define MR1D_LEVEL 7
`define MR1D_EQ_MID 6
`define MR1D_EQ_LO 5
`define MR1D_ADD_HI 4
`define MR1D_ADD_LO 3
`define MR1D_DRV_HI 2
`define MR1D_DRV_LO 1
`define MR1D_LOOP 0
`define MR1D_ADD_NONE 2'h0
`define MR1D_ADD_M1 2'h1
`define MR1D_ADD_M2 2'h2
`define MR1D_ADD_RSV 2'h3
`define MR1D_TERM_OFF 3'h0
`define MR1D_WTERM_OFF 3'h0
`define MR1D_LAT_W 6
`define MR1D_ONE_LAT 6'h01
`define MR1D_TWO_LAT 6'h02
`define MR1D_ZERO_LAT 6'h00
`endif

// >>> include/mr1d_pkg.sv
// Types for the second mode register decode block
package mr1d_pkg;
   typedef logic [21:0] mr1d_word_type;
   typedef logic [5:0] mr1d_lat_type;
   typedef enum logic [1:0] {
      MR1D_LOOP_OFF = 2'b00,
      MR1D_LOOP_ON = 2'b01,
      MR1D_LOOP_SLEEP = 2'b10
   } mr1d_loop_type;
endpackage

// >>> src/mr1d_core.sv
// Second mode register: capture on mode-set, decode and apply fields
`timescale 1ns/100ps
`include "mr1d_params.svh"
// Notes on behaviour
// - Bit 12 high disconnects output drivers and termination.
// - Bit 11 enables extra termination strobe, eight-bit width only.
// - Bits 10:8 select nominal termination, 000 off.
// - Bit 7 high enters write-leveling mode.
// - Bits 13, 6, 5 select receiver equalizer setting.
// - Bits 4:3 select adder: 0, latency minus one, minus two, reserved.
// - Bits 2:1 select driver strength; codes 10 and 11 reserved.
// - Bit 0 high enables the delay-locked loop.
// - Loop turns off in self refresh, back on at exit.
// - Writes work without loop unless write-time termination is on.
// - Write-time termination applies on writes even if nominal is off.
// - Parked termination applies whenever termination input is low and bit 12 is low.
// - Read or write after activate is held for the adder latency.
// - Read latency is adder plus read column; write likewise.
// - Extra termination strobe on blocks mask and bus inversion.
module mr1d_core (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic mode_set_i,
   input wire logic [1:0] bank_group_i,
   input wire logic [1:0] bank_i,
   input wire logic [17:0] addr_i,
   input wire logic is_x8_i,
   input wire logic self_refresh_i,
   input wire logic term_pin_i,
   input wire logic cmd_i,
   input wire logic cmd_is_write_i,
   input wire mr1d_pkg::mr1d_lat_type read_column_latency_i,
   input wire mr1d_pkg::mr1d_lat_type write_column_latency_i,
   input wire logic [2:0] write_time_termination_i,
   input wire logic [2:0] parked_termination_i,
   input wire logic mask_req_i,
   input wire logic inversion_req_i,
   output logic output_enable_o,
   output logic extra_termination_strobe_o,
   output logic [2:0] termination_o,
   output logic strobe_alignment_training_o,
   output logic [2:0] receiver_equalizer_o,
   output logic [1:0] driver_strength_o,
   output logic loop_running_o,
   output logic write_loop_ok_o,
   output mr1d_pkg::mr1d_lat_type read_latency_o,
   output mr1d_pkg::mr1d_lat_type write_latency_o,
   output logic exec_cmd_o,
   output logic exec_is_write_o,
   output logic write_byte_mask_o,
   output logic bus_inversion_o
);
   typedef struct packed {
      mr1d_pkg::mr1d_word_type mode_register_one;
      mr1d_pkg::mr1d_loop_type loop;
      logic sr_s1;
      logic sr_s2;
      logic tp_s1;
      logic tp_s2;
      logic oe;
      logic xs;
      logic [2:0] term;
      logic lvl;
      logic [2:0] eq;
      logic [1:0] drv;
      logic run;
      logic wok;
      mr1d_pkg::mr1d_lat_type rl;
      mr1d_pkg::mr1d_lat_type wl;
      logic mask;
      logic inv;
   } mr1d_core_type;
   mr1d_core_type state_reg;
   mr1d_core_type state_next;
   mr1d_pkg::mr1d_word_type cmd_word;
   mr1d_pkg::mr1d_lat_type adder;
   logic hit;
   logic in_write;

   // ----------------------------------------
   // Mode-set capture
   // ----------------------------------------
   assign cmd_word = {bank_group_i, bank_i, addr_i};
   assign hit = mode_set_i
      && cmd_word[`MR1D_SEL_HI:`MR1D_SEL_LO] == `MR1D_REG_INDEX;

   // ----------------------------------------
   // Adder decode
   // ----------------------------------------
   always_comb begin
      unique case (state_reg.mode_register_one[`MR1D_ADD_HI:`MR1D_ADD_LO])
         `MR1D_ADD_NONE: adder = `MR1D_ZERO_LAT;
         `MR1D_ADD_M1: adder = read_column_latency_i - `MR1D_ONE_LAT;
         `MR1D_ADD_M2: adder = read_column_latency_i - `MR1D_TWO_LAT;
         `MR1D_ADD_RSV: adder = `MR1D_ZERO_LAT;
      endcase
   end

   mr1d_delay_line u_hold (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .cmd_i(cmd_i),
      .is_write_i(cmd_is_write_i),
      .delay_i(adder),
      .cmd_o(exec_cmd_o),
      .is_write_o(exec_is_write_o)
   );
   assign in_write = exec_cmd_o && exec_is_write_o;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.sr_s1 = self_refresh_i;
      state_next.sr_s2 = state_reg.sr_s1;
      state_next.tp_s1 = term_pin_i;
      state_next.tp_s2 = state_reg.tp_s1;
      if (hit) begin
         state_next.mode_register_one = cmd_word;
      end
      unique case (state_reg.loop)
         mr1d_pkg::MR1D_LOOP_OFF: begin
            if (state_reg.mode_register_one[`MR1D_LOOP]) begin
               state_next.loop = mr1d_pkg::MR1D_LOOP_ON;
            end
         end
         mr1d_pkg::MR1D_LOOP_ON: begin
            if (!state_reg.mode_register_one[`MR1D_LOOP]) begin
               state_next.loop = mr1d_pkg::MR1D_LOOP_OFF;
            end else if (state_reg.sr_s2) begin
               state_next.loop = mr1d_pkg::MR1D_LOOP_SLEEP;
            end
         end
         mr1d_pkg::MR1D_LOOP_SLEEP: begin
            if (!state_reg.sr_s2) begin
               state_next.loop = mr1d_pkg::MR1D_LOOP_ON;
            end
         end
         default: state_next.loop = mr1d_pkg::MR1D_LOOP_OFF;
      endcase
      state_next.run = state_next.loop == mr1d_pkg::MR1D_LOOP_ON;
      state_next.oe = !state_reg.mode_register_one[`MR1D_OUT_OFF];
      state_next.xs = state_reg.mode_register_one[`MR1D_XSTROBE] && is_x8_i;
      state_next.mask = mask_req_i && !state_next.xs;
      state_next.inv = inversion_req_i && !state_next.xs;
      if (state_reg.mode_register_one[`MR1D_OUT_OFF]) begin
         state_next.term = `MR1D_TERM_OFF;
      end else if (!state_reg.tp_s2) begin
         state_next.term = parked_termination_i;
      end else if (in_write && write_time_termination_i != `MR1D_WTERM_OFF) begin
         state_next.term = write_time_termination_i;
      end else begin
         state_next.term = state_reg.mode_register_one[`MR1D_NOM_HI:`MR1D_NOM_LO];
      end
      state_next.lvl = state_reg.mode_register_one[`MR1D_LEVEL];
      state_next.eq = {state_reg.mode_register_one[`MR1D_EQ_HI],
         state_reg.mode_register_one[`MR1D_EQ_MID],
         state_reg.mode_register_one[`MR1D_EQ_LO]};
      state_next.drv = state_reg.mode_register_one[`MR1D_DRV_HI:`MR1D_DRV_LO];
      state_next.wok = state_next.run
         || write_time_termination_i == `MR1D_WTERM_OFF;
      state_next.rl = adder + read_column_latency_i;
      state_next.wl = adder + write_column_latency_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign output_enable_o = state_reg.oe;
   assign extra_termination_strobe_o = state_reg.xs;
   assign termination_o = state_reg.term;
   assign strobe_alignment_training_o = state_reg.lvl;
   assign receiver_equalizer_o = state_reg.eq;
   assign driver_strength_o = state_reg.drv;
   assign loop_running_o = state_reg.run;
   assign write_loop_ok_o = state_reg.wok;
   assign read_latency_o = state_reg.rl;
   assign write_latency_o = state_reg.wl;
   assign write_byte_mask_o = state_reg.mask;
   assign bus_inversion_o = state_reg.inv;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      !hit |=> $stable(state_reg.mode_register_one);
   endproperty
   a_hold: assert property (p_hold) else $error("register changed without mode-set");

   property p_off;
      @(posedge clk_i) disable iff (!rst_n_i)
      state_reg.mode_register_one[`MR1D_OUT_OFF]
         |=> !output_enable_o && termination_o == `MR1D_TERM_OFF;
   endproperty
   a_off: assert property (p_off) else $error("output disable ignored");

   property p_xs;
      @(posedge clk_i) disable iff (!rst_n_i)
      !is_x8_i |=> !extra_termination_strobe_o;
   endproperty
   a_xs: assert property (p_xs) else $error("strobe enabled on wrong width");

   property p_share;
      @(posedge clk_i) disable iff (!rst_n_i)
      extra_termination_strobe_o |-> !write_byte_mask_o && !bus_inversion_o;
   endproperty
   a_share: assert property (p_share) else $error("shared pin conflict");

   property p_park;
      @(posedge clk_i) disable iff (!rst_n_i)
      !state_reg.tp_s2 && !state_reg.mode_register_one[`MR1D_OUT_OFF]
         |=> termination_o == $past(parked_termination_i);
   endproperty
   a_park: assert property (p_park) else $error("parked value not applied");

   sequence s_enter;
      state_reg.loop == mr1d_pkg::MR1D_LOOP_ON && state_reg.sr_s2
         && state_reg.mode_register_one[`MR1D_LOOP];
   endsequence
   property p_sleep;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_enter |=> !loop_running_o;
   endproperty
   a_sleep: assert property (p_sleep) else $error("loop not stopped in self refresh");

   property p_lat;
      @(posedge clk_i) disable iff (!rst_n_i)
      $stable(adder) && $stable(read_column_latency_i)
         |=> read_latency_o == $past(adder) + $past(read_column_latency_i);
   endproperty
   a_lat: assert property (p_lat) else $error("read latency sum wrong");

   property p_zero;
      @(posedge clk_i) disable iff (!rst_n_i)
      cmd_i && adder == `MR1D_ZERO_LAT |=> exec_cmd_o;
   endproperty
   a_zero: assert property (p_zero) else $error("command not passed at zero adder");

   property p_lvl;
      @(posedge clk_i) disable iff (!rst_n_i)
      hit ##1 1'b1 |=> strobe_alignment_training_o == $past(addr_i[7], 2);
   endproperty
   a_lvl: assert property (p_lvl) else $error("leveling bit not applied");
endmodule

// >>> src/mr1d_delay_line.sv
// Command hold line: delays a command pulse by a programmable count
`timescale 1ns/100ps
`include "mr1d_params.svh"
module mr1d_delay_line (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_i,
   input wire logic is_write_i,
   input wire mr1d_pkg::mr1d_lat_type delay_i,
   output logic cmd_o,
   output logic is_write_o
);
   typedef struct packed {
      logic busy;
      logic wr;
      mr1d_pkg::mr1d_lat_type cnt;
      logic out;
      logic out_wr;
   } mr1d_dl_type;
   mr1d_dl_type state_reg;
   mr1d_dl_type state_next;

   // ----------------------------------------
   // Hold the command for the adder count
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.out = 1'b0;
      if (cmd_i && delay_i == `MR1D_ZERO_LAT) begin
         state_next.out = 1'b1;
         state_next.out_wr = is_write_i;
      end else if (cmd_i) begin
         state_next.busy = 1'b1;
         state_next.wr = is_write_i;
         state_next.cnt = delay_i - `MR1D_ONE_LAT;
      end else if (state_reg.busy) begin
         if (state_reg.cnt == `MR1D_ZERO_LAT) begin
            state_next.busy = 1'b0;
            state_next.out = 1'b1;
            state_next.out_wr = state_reg.wr;
         end else begin
            state_next.cnt = state_reg.cnt - `MR1D_ONE_LAT;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cmd_o = state_reg.out;
   assign is_write_o = state_reg.out_wr;
endmodule
